// ===== design/mss_sync.v
// multi-device alignment: arm control, first three reference pulses, status word, AHB-Lite slave
// assumes the reference pulse is synchronous to the reference clock and that clk is that clock
//
// Function
// [RQ1] source keeps the pulse low and disabled until every clock synthesizer is set up
// [RQ2] host sets the arm control to one while pulses are still disabled
// [RQ3] source sends at least three pulses to every device after arming
// [RQ4] armed devices finish alignment on the same three pulse edges
// [RQ5] only the first three pulses after arming align; later ones change nothing
// [RQ6] pulses after the third are still forwarded to the lane logic
// [RQ7] a new alignment needs a hard reset; re-arming alone does not restart
// [RQ8] host writes arm zero to read status before loading and calibrating
// [RQ9] source makes every pulse synchronous to the reference clock
// [RQ10] pulse train frequency is an integer submultiple of the multiframe rate
// [RQ11] pulse one resets scaler, two the core dividers, three aligns lanes
// [RQ12] four-bit status word, bits 0 to 3 set once their stage occurred
// [RQ13] status bits stay set and clear only on a hard reset
`timescale 1ns/1ps
`include "mss_sync_map.vh"
module mss_sync
(
	input  wire        clk,
	input  wire        sys_rst,
	input  wire        clk_en,
	input  wire        reference_pulse_in,
	input  wire        hsel,
	input  wire [7:0]  haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output reg         hreadyout,
	output reg         hresp,
	output reg         scaler_reset_q,
	output reg         divider_reset_q,
	output reg         lane_align_q,
	output reg         lane_pulse_q,
	output reg         sync_done_q,
	output reg         irq_q
);
	localparam ST_IDLE  = 2'd0;
	localparam ST_ARMED = 2'd1;
	localparam ST_DONE  = 2'd2;

	wire       pulse_rise;
	wire [3:0] irq_stat;
	wire       irq_w;
	wire       rd_req;
	wire       wr_req;
	wire       stage_fire;

	reg [1:0]  state_q;
	reg [1:0]  count_q;
	reg        arm_q;
	reg        used_q;
	reg [3:0]  status_q;
	reg [3:0]  mask_q;
	reg [3:0]  clr_d;
	reg [3:0]  evt_d;
	reg [`MSS_CNT_W-1:0] pulses_q;
	reg        ph_wr_q;
	reg [7:0]  ph_addr_q;

	function [31:0] rd_mux;
		input [7:0] a;
		input       arm;
		input [3:0] st;
		input [3:0] is;
		input [3:0] mk;
		input [`MSS_CNT_W-1:0] pc;
		input [1:0] sm;
		begin
			case (a)
				`MSS_OFF_CTRL:     rd_mux = {30'h0, sm == ST_DONE, arm};
				`MSS_OFF_STATUS:   rd_mux = {28'h0, st};
				`MSS_OFF_IRQ_STAT: rd_mux = {28'h0, is};
				`MSS_OFF_IRQ_MASK: rd_mux = {28'h0, mk};
				`MSS_OFF_PULSES:   rd_mux = {16'h0, pc};
				default:           rd_mux = 32'h0;
			endcase
		end
	endfunction

	// registers are whole aligned words, the two low address bits are ignored
	function [7:0] word_addr;
		input [7:0] a;
		begin
			word_addr = {a[7:2], 2'b00};
		end
	endfunction

	// status bits and stage events raised by the aligning pulse with index n
	function [3:0] stage_mask;
		input [1:0] n;
		begin
			case (n)
				2'd0:    stage_mask = 4'b0001;
				2'd1:    stage_mask = 4'b0110;
				default: stage_mask = 4'b1000;
			endcase
		end
	endfunction

	assign rd_req     = hsel & htrans[1] & ~hwrite;
	assign wr_req     = hsel & htrans[1] & hwrite;
	assign stage_fire = (state_q == ST_ARMED) && pulse_rise;

	mss_sync_pulse_det u_det
	(
		.clk     (clk),
		.sys_rst (sys_rst),
		.clk_en  (clk_en),
		.pin_in  (reference_pulse_in),
		.rise_q  (pulse_rise)
	);

	// interrupt events: one per stage status bit
	always @*
	begin
		evt_d = 4'h0;
		if (stage_fire)
			evt_d = stage_mask(count_q); // RQ12
	end

	// the clear lands at the end of the write's data phase, so a read right behind it still sees the old bits
	always @*
	begin
		clr_d = 4'h0;
		if (ph_wr_q && ph_addr_q == `MSS_OFF_IRQ_STAT)
			clr_d = hwdata[3:0];
	end

	mss_sync_irq #(.W(4)) u_irq
	(
		.clk      (clk),
		.sys_rst  (sys_rst),
		.clk_en   (clk_en),
		.event_in (evt_d),
		.clr_in   (clr_d),
		.mask_in  (mask_q),
		.stat_q   (irq_stat),
		.irq_q    (irq_w)
	);

	always @(posedge clk)
	begin
		if (sys_rst)
			irq_q <= 1'b0;
		else if (clk_en)
			irq_q <= irq_w;
	end

	// zero wait states, and every transfer is answered OKAY
	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
		else if (clk_en)
		begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// AHB-Lite address phase
	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			ph_wr_q   <= 1'b0;
			ph_addr_q <= 8'h00;
		end
		else if (clk_en && hready)
		begin
			ph_wr_q   <= wr_req;
			ph_addr_q <= word_addr(haddr);
		end
	end

	// read data is taken in the address phase and stands until the next read
	always @(posedge clk)
	begin
		if (sys_rst)
			hrdata <= 32'h0;
		else if (clk_en && hready && rd_req)
			hrdata <= rd_mux(word_addr(haddr), arm_q, status_q, irq_stat, mask_q,
				pulses_q, state_q);
	end

	// register writes land at the end of the data phase
	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			arm_q  <= `MSS_CTRL_RST;
			mask_q <= `MSS_MASK_RST;
		end
		else if (clk_en && ph_wr_q)
		begin
			if (ph_addr_q == `MSS_OFF_CTRL)
				arm_q <= hwdata[`MSS_CTRL_ARM_BIT];
			if (ph_addr_q == `MSS_OFF_IRQ_MASK)
				mask_q <= hwdata[3:0];
		end
	end

	// every pulse edge seen while clk_en is high is counted, armed or not; the count saturates
	always @(posedge clk)
	begin
		if (sys_rst)
			pulses_q <= {`MSS_CNT_W{1'b0}};
		else if (clk_en && pulse_rise && pulses_q != {`MSS_CNT_W{1'b1}})
			pulses_q <= pulses_q + {{(`MSS_CNT_W-1){1'b0}}, 1'b1};
	end

	// alignment state machine; arming is consumed once per hard reset
	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			state_q <= ST_IDLE;
			count_q <= 2'd0;
			used_q  <= 1'b0;
		end
		else if (clk_en)
		begin
			case (state_q)
				ST_IDLE:
				begin
					if (arm_q && !used_q) // RQ7
					begin
						state_q <= ST_ARMED;
						used_q  <= 1'b1;
					end
				end
				ST_ARMED:
				begin
					if (pulse_rise) // RQ4
					begin
						count_q <= count_q + 2'd1;
						if (count_q == `MSS_LAST_STAGE)
							state_q <= ST_DONE;
					end
				end
				ST_DONE:
				begin
					// later pulses and re-arming change nothing
					state_q <= ST_DONE; // RQ5 RQ7
				end
				default:
					state_q <= ST_IDLE;
			endcase
		end
	end

	// stage pulses last one cycle; pulses after the third only reach the lanes
	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			scaler_reset_q  <= 1'b0;
			divider_reset_q <= 1'b0;
			lane_align_q    <= 1'b0;
			lane_pulse_q    <= 1'b0;
		end
		else if (clk_en)
		begin
			scaler_reset_q  <= 1'b0;
			divider_reset_q <= 1'b0;
			lane_align_q    <= 1'b0;
			lane_pulse_q    <= 1'b0;
			if (stage_fire)
			begin
				case (count_q) // RQ11
					2'd0:
						scaler_reset_q <= 1'b1;
					2'd1:
						divider_reset_q <= 1'b1;
					default:
					begin
						lane_align_q <= 1'b1;
						lane_pulse_q <= 1'b1;
					end
				endcase
			end
			else if (state_q == ST_DONE && pulse_rise)
				lane_pulse_q <= 1'b1; // RQ6 RQ5
		end
	end

	// status word and done flag hold until a hard reset
	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			status_q    <= `MSS_STATUS_RST;
			sync_done_q <= 1'b0;
		end
		else if (clk_en)
		begin
			status_q <= status_q | evt_d; // RQ12 RQ13
			if (stage_fire && count_q == `MSS_LAST_STAGE)
				sync_done_q <= 1'b1; // RQ13
		end
	end
endmodule

// ===== design/mss_sync_irq.v
// sticky event bits with write-one-to-clear and a mask onto one level interrupt
// assumes events are one-cycle pulses on clk
`timescale 1ns/1ps
`include "mss_sync_map.vh"
module mss_sync_irq
#(
	parameter W = 4
)
(
	input  wire         clk,
	input  wire         sys_rst,
	input  wire         clk_en,
	input  wire [W-1:0] event_in,
	input  wire [W-1:0] clr_in,
	input  wire [W-1:0] mask_in,
	output reg  [W-1:0] stat_q,
	output reg          irq_q
);
	wire [W-1:0] stat_d;

	// a set in the clearing cycle wins
	assign stat_d = (stat_q & ~clr_in) | event_in;

	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			stat_q <= {W{1'b0}};
			irq_q  <= 1'b0;
		end
		else if (clk_en)
		begin
			stat_q <= stat_d;
			irq_q  <= |(stat_d & mask_in);
		end
	end
endmodule

// ===== design/mss_sync_map.vh
// register map, field positions and reset values of the multi-device alignment block
// included by every design file of the block except the pulse detector; definitions only
`ifndef MSS_SYNC_MAP_VH
`define MSS_SYNC_MAP_VH

`define MSS_OFF_CTRL      8'h00
`define MSS_OFF_STATUS    8'h04
`define MSS_OFF_IRQ_STAT  8'h08
`define MSS_OFF_IRQ_MASK  8'h0c
`define MSS_OFF_PULSES    8'h10

`define MSS_CTRL_ARM_BIT  0
`define MSS_CTRL_RST      1'b0
`define MSS_MASK_RST      4'h0
`define MSS_STATUS_RST    4'h0
`define MSS_LAST_STAGE    2'd2
`define MSS_PULSES_SYNC   3
`define MSS_CNT_W         16

`define MSS_HTRANS_NONSEQ 2'b10
`define MSS_HTRANS_SEQ    2'b11

`endif

// ===== design/mss_sync_pulse_det.v
// two-flop synchroniser and rising-edge detector for the reference pulse pin
// assumes the pulse is a level from outside the clock domain
`timescale 1ns/1ps
module mss_sync_pulse_det
(
	input  wire clk,
	input  wire sys_rst,
	input  wire clk_en,
	input  wire pin_in,
	output reg  rise_q
);
	reg meta_q;
	reg sync_q;
	reg prev_q;

	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			prev_q <= 1'b0;
			rise_q <= 1'b0;
		end
		else if (clk_en)
		begin
			meta_q <= pin_in;
			sync_q <= meta_q;
			prev_q <= sync_q;
			rise_q <= sync_q & ~prev_q;
		end
	end
endmodule

// ===== tb/mss_pulse_src.sv
// reference pulse source: one clk-synchronous pulse per request
// assumes go is a one-cycle request
`timescale 1ns/1ps
module mss_pulse_src
(
	input  wire logic       clk,
	input  wire logic       go,
	input  wire logic [2:0] hi,
	output wire logic       pin,
	output wire logic       busy
);
	logic [4:0] t_q = 5'h0;
	assign busy = t_q != 5'h0;
	// high hi+1 cycles, then low for 15-hi cycles of a fixed 16-cycle slot; low when idle
	assign pin = t_q > 5'h0f - {2'h0, hi};
	always @(posedge clk)
		t_q <= go && !busy ? 5'h10 : t_q - {4'h0, busy};
endmodule

// ===== tb/mss_sync_sva.sv
// checker: order of the alignment stage pulses and the done flag
// assumes stage outputs stand still while clk_en is low
`timescale 1ns/1ps
module mss_sync_sva
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic scaler_reset_q,
	input wire logic divider_reset_q,
	input wire logic lane_align_q,
	input wire logic lane_pulse_q,
	input wire logic sync_done_q
);
	logic [1:0] n_q;
	wire        stg = scaler_reset_q || divider_reset_q || lane_align_q;
	// stage pulses seen since reset, saturating
	always @(posedge clk)
		n_q <= sys_rst ? 2'h0 : n_q + {1'b0, clk_en && stg && n_q != 2'h3};
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	AST_FIRST: assert property (scaler_reset_q |-> n_q == 2'h0)
		else $error("scaler reset out of turn");
	AST_SECOND: assert property (divider_reset_q |-> n_q == 2'h1)
		else $error("divider reset out of turn");
	AST_THIRD: assert property (lane_align_q |-> n_q == 2'h2 && lane_pulse_q)
		else $error("lane align out of turn");
	AST_NO_MORE: assert property (n_q == 2'h3 |-> !stg)
		else $error("stage pulse after the third");
	AST_ONEHOT: assert property ($onehot0({scaler_reset_q, divider_reset_q, lane_align_q}))
		else $error("two stages at once");
	AST_DONE: assert property (lane_align_q |-> ##[0:2] sync_done_q)
		else $error("done missing");
	AST_EARLY: assert property (sync_done_q |-> n_q == 2'h3 || lane_align_q)
		else $error("done too early");
	AST_HOLD: assert property (sync_done_q |=> sync_done_q)
		else $error("done dropped");
endmodule
bind mss_sync mss_sync_sva chk_i (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .scaler_reset_q(scaler_reset_q),
	.divider_reset_q(divider_reset_q), .lane_align_q(lane_align_q), .lane_pulse_q(lane_pulse_q),
	.sync_done_q(sync_done_q));

// ===== tb/test_multichip_sysref_sync.sv
// bench: bus master and pulse source around the alignment block
// assumes clk_en high except for one pulse in each of the two reset passes, which must be ignored
`timescale 1ns/1ps
module test_multichip_sysref_sync;
	logic        clk = 0, sys_rst = 1, hsel = 0, hwrite = 0, go = 0, en = 1;
	logic [7:0]  haddr = 0;
	logic [1:0]  htrans = 0;
	logic [31:0] hwdata = 0, r;
	logic [2:0]  hi = 0;
	logic [3:0]  m;
	wire         hrdy, pin, busy, irq, lp, hr;
	wire  [31:0] hrdata;
	int          n_mismatch = 0, checks_done = 0, n_lane;
	always #2.5 clk = ~clk;
	mss_sync uut (.clk(clk), .sys_rst(sys_rst), .clk_en(en), .reference_pulse_in(pin), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy),
		.hrdata(hrdata), .hreadyout(hrdy), .hresp(hr), .scaler_reset_q(), .divider_reset_q(),
		.lane_align_q(), .lane_pulse_q(lp), .sync_done_q(), .irq_q(irq));
	mss_pulse_src src (.clk(clk), .go(go), .hi(hi), .pin(pin), .busy(busy));
	always @(posedge clk)
		n_lane += (lp === 1'b1);
	task chk(input string nm, input [31:0] got, exp);
		checks_done++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("wrong value %s exp %h got %h", nm, exp, got);
		end
	endtask
	task bus(input [7:0] a, input w, input [31:0] d);
		haddr <= a;
		hwrite <= w;
		htrans <= 2'b10;
		hsel <= 1'b1;
		do @(posedge clk); while (hrdy !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk); while (hrdy !== 1'b1);
		r = hrdata;
	endtask
	task rd(input [7:0] a, input [31:0] e, input string nm);
		bus(a, 1'b0, 0);
		chk(nm, r, e);
		chk("hresp", hr, 0);
	endtask
	task fire(input int n);
		repeat (n)
		begin
			hi <= 3'($urandom);
			go <= 1'b1;
			@(posedge clk);
			go <= 1'b0;
			do @(posedge clk); while (busy);
		end
		repeat (6) @(posedge clk);
	endtask
	function [31:0] exp_st(input int n);
		return n > 2 ? 32'hf : n == 2 ? 32'h7 : n;
	endfunction
	task finish_test;
		$display("mismatches %0d checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial
	begin
		void'($urandom(21344));
		for (int k = 0; k < 2; k++)
		begin
			sys_rst <= 1'b1;
			repeat (2) @(posedge clk);
			sys_rst <= 1'b0;
			@(posedge clk);
			n_lane = 0;
			rd(8'h04, 0, "status");
			rd(8'h00, 0, "ctrl");
			rd(8'h14, 0, "unmapped");
			fire(1);
			rd(8'h04, 0, "status");
			en <= 1'b0;
			fire(1);
			en <= 1'b1;
			rd(8'h10, 1, "pulses");
			m = 4'($urandom);
			bus(8'h0c, 1'b1, m);
			rd(8'h0c, m, "mask");
			bus(8'h00, 1'b1, 1);
			for (int i = 1; i < 4; i++)
			begin
				fire(1);
				rd(8'h04, exp_st(i), "status");
			end
			rd(8'h00, 3, "ctrl");
			rd(8'h08, 32'hf, "irq_stat");
			chk("irq", irq, m != 0);
			bus(8'h08, 1'b1, 32'hf);
			fire(2);
			chk("irq", irq, 0);
			rd(8'h08, 0, "irq_stat");
			chk("lanes", n_lane, 3);
			rd(8'h10, 6, "pulses");
			bus(8'h00, 1'b1, 0);
			rd(8'h04, 32'hf, "status");
			bus(8'h00, 1'b1, 1);
			fire(1);
			rd(8'h04, 32'hf, "status");
			rd(8'h08, 0, "irq_stat");
		end
		finish_test;
	end
	initial
	begin
		#50000;
		n_mismatch++;
		finish_test;
	end
endmodule
